/* File: core/mms_top.sv */
// relay stager for auxiliary motors with axi4-lite registers
//
// Behaviour
// - run time since last auto-change kept as readable hours and minutes.
// - attached auxiliary motor count setting, default four, limits staging.
// - motor starts above its start frequency, after delay, pressure gap high.
// - motors stop highest first below stop frequency, after delay, gap low.
// - start delay counted while start condition holds.
// - separate stop delay counted while stop condition holds.
// - count change selects staging accel or decel time, tenths of second.
// - bypass drives frequency from feedback, also used as stage reference.
// - bypass adds relay at maximum frequency, main restarts from start.
// - bypass disables regulator, forces v/f, needs analogue or pulse source.
// - sleep after running below sleep frequency for the sleep delay.
// - asleep, resume once feedback falls below wake level.
// - zero sleep delay disables sleep.
// - mode 0 fixed first relay, cyclic upward on, reverse off.
// - mode 1 like mode 0, auto-change advances first motor.
// - mode 2 all motors on relays, rotation as mode 1.
// - auto-change needs time, low level, and mode-specific motor count.
// - auto-change stops motor, advances order, continues in new order.
// - auto-change timer advances only while an auxiliary motor runs.
// - mode 2 output frequency below level also triggers auto-change.
// - interlock inputs mark motors usable, unusable ones are skipped.
// - interlock dropping while running releases all, restages without it.
// - setting selects first staged motor, default motor one.
`timescale 1ns/10ps
`include "mms_defs.svh"
module mms_top #(
  parameter int TICK_CYCLES = `MMS_TICK_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [15:0] out_freq,
  input  wire logic [15:0] reference,
  input  wire logic [15:0] feedback,
  input  wire logic [15:0] regulator_freq,
  input  wire logic [3:0]  interlock_inputs,
  output logic [3:0]       staged_motor_outputs,
  output logic             drive_run,
  output logic [15:0]      cmd_freq,
  output logic [15:0]      ramp_time,
  output logic             ramp_up,
  output logic             bypass_restart,
  output logic             pid_enable,
  output logic             vf_force,
  output logic             asleep
);
  logic [31:0]        cfg_q [`MMS_NUM_CFG];
  logic               aw_full_q, w_full_q;
  logic [4:0]         aw_idx_q;
  logic               aw_bad_q;
  logic [31:0]        wdata_q;
  logic [3:0]         wstrb_q;
  logic [21:0]        div_q;
  logic               tick;
  mms_pkg::mms_state_t st_q;
  logic [2:0]         cnt_q;
  logic [3:0]         relay_q;
  logic               kick_q;
  logic [1:0]         adv_q;
  logic [9:0]         sub_q;
  logic [5:0]         min_q;
  logic [7:0]         hour_q;
  logic [15:0]        tot_min_q;
  logic [15:0]        ramp_q;
  logic               ramp_up_q, restart_q;
  logic [15:0]        cmd_q;
  logic [1:0]         pos;
  logic               bypass_ok;

  ////////////////////////////////////////////////////////////////////////
  // functions

  // reset value of each setting word
  function automatic logic [31:0] rst_val(input int i);
    if (i == int'(`MMS_IDX_AUXCFG)) return `MMS_RST_AUXCFG;
    if (i >= int'(`MMS_IDX_START) && i < int'(`MMS_IDX_STOP))
      return `MMS_RST_START;
    if (i >= int'(`MMS_IDX_STOP) && i < int'(`MMS_IDX_ON_DLY))
      return `MMS_RST_STOP;
    if (i == int'(`MMS_IDX_ON_DLY) || i == int'(`MMS_IDX_OFF_DLY))
      return `MMS_RST_DLY;
    if (i == int'(`MMS_IDX_RAMP)) return `MMS_RST_RAMP;
    if (i == int'(`MMS_IDX_PR_DIFF)) return `MMS_RST_PR_DIFF;
    if (i == int'(`MMS_IDX_MAX_FREQ)) return `MMS_RST_MAX_FREQ;
    return 32'h0000_0000;
  endfunction

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  // relays closed for a count, cyclic from the first motor
  function automatic logic [3:0] stage_mask(input logic [1:0] pos,
                                            input logic [2:0] n,
                                            input logic [3:0] usable,
                                            input logic [2:0] cnt);
    logic [3:0] m;
    logic [2:0] c;
    logic [2:0] p;
    m = 4'h0;
    c = 3'd0;
    p = {1'b0, pos};
    for (int k = 0; k < 4; k++) begin
      if (3'(k) < n) begin
        if (usable[p[1:0]] && c < cnt) begin
          m[p[1:0]] = 1'b1;
          c = c + 3'd1;
        end
        p = (p + 3'd1 == n) ? 3'd0 : p + 3'd1;
      end
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  wire wr_go = aw_full_q && w_full_q && !s_axi_bvalid;
  assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // address and data captured in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_idx_q  <= 5'd0;
      aw_bad_q  <= 1'b0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[6:2];
        aw_bad_q  <= s_axi_awaddr[31:7] != 25'd0 ||
                     s_axi_awaddr[6:2] >= 5'(`MMS_NUM_CFG);
      end else if (wr_go) begin
        aw_full_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_full_q <= 1'b0;
      end
    end
  end

  // write response, slverr for unmapped or read-only words
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= aw_bad_q ? 2'b10 : 2'b00;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // setting words
  generate
    for (genvar i = 0; i < `MMS_NUM_CFG; i++) begin : g_cfg
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cfg_q[i] <= rst_val(i);
        end else if (wr_go && !aw_bad_q && aw_idx_q == 5'(i)) begin
          cfg_q[i] <= merge(cfg_q[i], wdata_q, wstrb_q);
        end
      end
    end
  endgenerate

  // read data, settings then status words
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      s_axi_rdata  <= 32'h0000_0000;
      if (s_axi_araddr[31:7] != 25'd0) begin
        s_axi_rresp <= 2'b10;
      end else if (s_axi_araddr[6:2] < 5'(`MMS_NUM_CFG)) begin
        s_axi_rdata <= cfg_q[s_axi_araddr[6:2]];
      end else if (s_axi_araddr[6:2] == `MMS_IDX_STATUS) begin
        s_axi_rdata <= {19'd0, bypass_ok, relay_q, pos, st_q, 1'b0, cnt_q};
      end else if (s_axi_araddr[6:2] == `MMS_IDX_RUNTIME) begin
        s_axi_rdata <= {16'd0, hour_q, 2'b00, min_q};
      end else begin
        s_axi_rresp <= 2'b10;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // settings decode

  wire [31:0] ctrl    = cfg_q[`MMS_IDX_CTRL];
  wire [31:0] auxcfg  = cfg_q[`MMS_IDX_AUXCFG];
  wire        run_cmd = ctrl[`MMS_CTRL_RUN];
  wire        ilk_en  = ctrl[`MMS_CTRL_ILK];
  wire [1:0]  mode    = ctrl[`MMS_CTRL_MODE_LO +: 2];
  wire [1:0]  src     = ctrl[`MMS_CTRL_SRC_LO +: 2];
  wire [2:0]  ncfg    = auxcfg[`MMS_AUX_CNT_LO +: 3];
  wire [2:0]  first   = auxcfg[`MMS_AUX_FIRST_LO +: 3];
  // out-of-range counts fall back to four motors
  wire [2:0]  n_aux   = (ncfg == 3'd0 || ncfg > `MMS_NUM_AUX) ?
                        `MMS_NUM_AUX : ncfg;
  // first motor setting is one-based
  wire [2:0]  base    = (first == 3'd0 || first > n_aux) ?
                        3'd0 : first - 3'd1;
  wire [2:0]  pos_sum = base + {1'b0, adv_q};
  wire [2:0]  pos_w   = (pos_sum >= n_aux) ? pos_sum - n_aux : pos_sum;
  assign pos       = pos_w[1:0];
  assign bypass_ok = ctrl[`MMS_CTRL_BYPASS] &&
                     src != mms_pkg::SRC_KEYPAD;
  wire [3:0]  usable  = ilk_en ? interlock_inputs : 4'hf;
  wire [3:0]  full_m  = stage_mask(pos, n_aux, usable, `MMS_NUM_AUX);
  wire [2:0]  max_cnt = 3'(full_m[0]) + 3'(full_m[1]) +
                        3'(full_m[2]) + 3'(full_m[3]);

  ////////////////////////////////////////////////////////////////////////
  // tick and delay timers

  // one pulse every 0.1 s
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 22'd0;
    end else if (div_q == 22'(TICK_CYCLES - 1)) begin
      div_q <= 22'd0;
    end else begin
      div_q <= div_q + 22'd1;
    end
  end
  assign tick = (div_q == 22'(TICK_CYCLES - 1));

  mms_tmr_if tmr [3] ();
  generate
    for (genvar j = 0; j < 3; j++) begin : g_tmr
      mms_dly_timer u_tmr (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (tick),
        .t       (tmr[j])
      );
    end
  endgenerate

  // stage reference is feedback in bypass
  wire [15:0] ref_f  = bypass_ok ? feedback : out_freq;
  wire signed [16:0] gap = $signed({1'b0, reference}) -
                           $signed({1'b0, feedback});
  wire signed [16:0] thr = $signed({1'b0, cfg_q[`MMS_IDX_PR_DIFF][15:0]});
  wire [15:0] on_f   = cfg_q[`MMS_IDX_START + 5'(cnt_q[1:0])][15:0];
  wire [15:0] off_f  = cfg_q[`MMS_IDX_STOP + 5'(cnt_q[1:0] - 2'd1)][15:0];
  wire [15:0] max_f  = cfg_q[`MMS_IDX_MAX_FREQ][15:0];
  wire        live   = st_q == mms_pkg::ST_RUN && !kick_q;
  // bypass stages when the main motor reaches maximum frequency
  wire on_cond  = live && cnt_q < max_cnt && gap > thr &&
                  (bypass_ok ? out_freq >= max_f : ref_f > on_f);
  wire off_cond = live && cnt_q != 3'd0 && gap < thr &&
                  ref_f < off_f;
  wire [15:0] slp_dly = cfg_q[`MMS_IDX_SLP_DLY][15:0];
  wire slp_cond = st_q == mms_pkg::ST_RUN && slp_dly != 16'h0000 &&
                  out_freq < cfg_q[`MMS_IDX_SLP_FREQ][15:0];

  assign tmr[0].cond  = on_cond;
  assign tmr[0].limit = cfg_q[`MMS_IDX_ON_DLY][15:0];
  assign tmr[1].cond  = off_cond;
  assign tmr[1].limit = cfg_q[`MMS_IDX_OFF_DLY][15:0];
  assign tmr[2].cond  = slp_cond;
  assign tmr[2].limit = slp_dly;
  wire on_go  = tmr[0].done;
  wire off_go = tmr[1].done && !on_go;

  ////////////////////////////////////////////////////////////////////////
  // operating state

  wire [15:0] rot_lvl = cfg_q[`MMS_IDX_ROT_LVL][15:0];
  wire lvl_ok  = feedback < rot_lvl ||
                 (mode == 2'd2 && out_freq < rot_lvl);
  wire cnt_ok  = (mode == 2'd1 && cnt_q == 3'd0) ||
                 (mode == 2'd2 && cnt_q == 3'd1);
  wire ac_fire = st_q == mms_pkg::ST_RUN && mode != 2'd0 && lvl_ok &&
                 cnt_ok && tot_min_q >= cfg_q[`MMS_IDX_ROT_TIME][15:0];
  wire ilk_trip = ilk_en && |(relay_q & ~interlock_inputs);

  // run, sleep and auto-change sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= mms_pkg::ST_STOP;
    end else begin
      case (st_q)
        mms_pkg::ST_STOP: begin
          if (run_cmd) st_q <= mms_pkg::ST_RUN;
        end
        mms_pkg::ST_RUN: begin
          if (!run_cmd) st_q <= mms_pkg::ST_STOP;
          else if (tmr[2].done) st_q <= mms_pkg::ST_SLEEP;
          else if (ac_fire) st_q <= mms_pkg::ST_CHANGE;
        end
        mms_pkg::ST_SLEEP: begin
          if (!run_cmd) st_q <= mms_pkg::ST_STOP;
          else if (feedback < cfg_q[`MMS_IDX_WAKE][15:0])
            st_q <= mms_pkg::ST_RUN;
        end
        mms_pkg::ST_CHANGE: begin
          if (tick) st_q <= mms_pkg::ST_RUN;
        end
        default: st_q <= mms_pkg::ST_STOP;
      endcase
    end
  end

  // staged count, released outside running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q     <= 3'd0;
      kick_q    <= 1'b0;
      ramp_q    <= 16'h0000;
      ramp_up_q <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      kick_q    <= 1'b0;
      restart_q <= 1'b0;
      if (st_q == mms_pkg::ST_CHANGE) begin
        cnt_q <= (tick && mode == 2'd2) ? 3'd1 : 3'd0;
      end else if (st_q != mms_pkg::ST_RUN || ilk_trip) begin
        cnt_q <= 3'd0;
      end else if (cnt_q > max_cnt) begin
        cnt_q <= max_cnt;
      end else if (on_go) begin
        cnt_q     <= cnt_q + 3'd1;
        kick_q    <= 1'b1;
        ramp_q    <= cfg_q[`MMS_IDX_RAMP][15:0];
        ramp_up_q <= 1'b1;
        restart_q <= bypass_ok;
      end else if (off_go) begin
        cnt_q     <= cnt_q - 3'd1;
        kick_q    <= 1'b1;
        ramp_q    <= cfg_q[`MMS_IDX_RAMP][31:16];
        ramp_up_q <= 1'b0;
      end
    end
  end

  // relays follow the count along the cyclic order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      relay_q <= 4'h0;
    end else if (ilk_trip) begin
      relay_q <= 4'h0;
    end else begin
      relay_q <= stage_mask(pos, n_aux, usable, cnt_q);
    end
  end

  // first motor advances on each auto-change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adv_q <= 2'd0;
    end else if (st_q == mms_pkg::ST_RUN && ac_fire) begin
      adv_q <= (3'(adv_q) + 3'd1 >= n_aux) ? 2'd0 : adv_q + 2'd1;
    end
  end

  // run time since the last auto-change
  always_ff @(posedge aclk) begin
    if (!aresetn || st_q == mms_pkg::ST_CHANGE) begin
      sub_q     <= 10'd0;
      min_q     <= 6'd0;
      hour_q    <= 8'd0;
      tot_min_q <= 16'h0000;
    end else if (tick && cnt_q != 3'd0) begin
      sub_q <= sub_q + 10'd1;
      if (sub_q == `MMS_TICKS_PER_MIN) begin
        sub_q     <= 10'd0;
        tot_min_q <= (tot_min_q == 16'hffff) ? tot_min_q :
                     tot_min_q + 16'h0001;
        if (min_q == 6'd59) begin
          min_q  <= 6'd0;
          hour_q <= hour_q + 8'd1;
        end else begin
          min_q <= min_q + 6'd1;
        end
      end
    end
  end

  // commanded frequency source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_q <= 16'h0000;
    end else begin
      cmd_q <= bypass_ok ? feedback : regulator_freq;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign staged_motor_outputs = relay_q;
  assign drive_run      = st_q == mms_pkg::ST_RUN;
  assign cmd_freq       = cmd_q;
  assign ramp_time      = ramp_q;
  assign ramp_up        = ramp_up_q;
  assign bypass_restart = restart_q;
  assign pid_enable     = !bypass_ok;
  assign vf_force       = bypass_ok;
  assign asleep         = st_q == mms_pkg::ST_SLEEP;
endmodule

/* File: core/mms_defs.svh */
// constants of the relay stager: offsets, fields, reset values, timing
`ifndef MMS_DEFS_SVH
`define MMS_DEFS_SVH
// register word indices, byte address is index times four
`define MMS_IDX_CTRL      5'd0
`define MMS_IDX_AUXCFG    5'd1
`define MMS_IDX_START     5'd2
`define MMS_IDX_STOP      5'd6
`define MMS_IDX_ON_DLY    5'd10
`define MMS_IDX_OFF_DLY   5'd11
`define MMS_IDX_RAMP      5'd12
`define MMS_IDX_PR_DIFF   5'd13
`define MMS_IDX_SLP_DLY   5'd14
`define MMS_IDX_SLP_FREQ  5'd15
`define MMS_IDX_WAKE      5'd16
`define MMS_IDX_ROT_TIME  5'd17
`define MMS_IDX_ROT_LVL   5'd18
`define MMS_IDX_MAX_FREQ  5'd19
`define MMS_IDX_STATUS    5'd20
`define MMS_IDX_RUNTIME   5'd21
`define MMS_NUM_CFG       20
// control and auxiliary config fields
`define MMS_CTRL_RUN      0
`define MMS_CTRL_BYPASS   1
`define MMS_CTRL_ILK      2
`define MMS_CTRL_MODE_LO  4
`define MMS_CTRL_SRC_LO   8
`define MMS_AUX_CNT_LO    0
`define MMS_AUX_FIRST_LO  4
// reset values
`define MMS_RST_AUXCFG    32'h0000_0014
`define MMS_RST_START     32'h0000_1387
`define MMS_RST_STOP      32'h0000_0bb8
`define MMS_RST_DLY       32'h0000_0032
`define MMS_RST_RAMP      32'h0032_0032
`define MMS_RST_PR_DIFF   32'h0000_0002
`define MMS_RST_MAX_FREQ  32'h0000_1770
`define MMS_NUM_AUX       3'd4
// timing: one tick is 0.1 s
`define MMS_CLK_NS        40
`define MMS_TICK_NS       100000000
`define MMS_TICK_CYC      (`MMS_TICK_NS / `MMS_CLK_NS)
`define MMS_TICKS_PER_MIN 10'd599
`endif

/* File: core/mms_pkg.sv */
// types of the relay stager
package mms_pkg;
  typedef enum logic [1:0] {
    ST_STOP   = 2'b00,
    ST_RUN    = 2'b01,
    ST_SLEEP  = 2'b10,
    ST_CHANGE = 2'b11
  } mms_state_t;
  typedef enum logic [1:0] {
    SRC_KEYPAD = 2'b00,
    SRC_V1     = 2'b01,
    SRC_I      = 2'b10,
    SRC_PULSE  = 2'b11
  } mms_src_t;
endpackage

/* File: core/mms_tmr_if.sv */
// condition, limit and expiry of one delay timer
`timescale 1ns/10ps
interface mms_tmr_if;
  logic        cond;
  logic [15:0] limit;
  logic        done;
  modport tmr (input cond, input limit, output done);
  modport user (output cond, output limit, input done);
endinterface

/* File: core/mms_dly_timer.sv */
// delay timer counting ticks while its condition holds
`timescale 1ns/10ps
module mms_dly_timer (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic tick,
  mms_tmr_if.tmr    t
);
  logic [15:0] cnt_q;

  // clears as soon as the condition lapses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 16'h0000;
    end else if (!t.cond) begin
      cnt_q <= 16'h0000;
    end else if (tick && cnt_q != t.limit) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign t.done = t.cond && (cnt_q == t.limit);
endmodule

/* File: tb/mms_relay_model.sv */
// interlock terminals of the contactors at the stager's far side
`timescale 1ns/10ps
module mms_relay_model (
  input  wire logic       aclk,
  input  wire logic [3:0] fault,
  output logic [3:0]      interlock_inputs
);
  // terminal opens one clock after its motor faults
  always_ff @(posedge aclk) begin
    interlock_inputs <= ~fault;
  end
endmodule

/* File: tb/mms_top_checker.sv */
// port assertions of the relay stager
`timescale 1ns/10ps
module mms_top_checker #(
  parameter int TICK_CYCLES = 20
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [15:0] feedback,
  input wire logic [15:0] regulator_freq,
  input wire logic [3:0]  staged_motor_outputs,
  input wire logic [3:0]  interlock_inputs,
  input wire logic        drive_run,
  input wire logic [15:0] cmd_freq,
  input wire logic        ramp_up,
  input wire logic        bypass_restart,
  input wire logic        pid_enable,
  input wire logic        vf_force,
  input wire logic        asleep
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [2:0] n_on;
  //////////////////////////////////////////////////////////////////////////
  // number of closed relays
  assign n_on = 3'($countones(staged_motor_outputs));
  chk_mode_flags:
    assert property (pid_enable != vf_force) else $error("bypass flags");
  chk_bypass_cmd:
    assert property ($past(aresetn) && vf_force && $past(vf_force)
      |-> cmd_freq == $past(feedback)) else $error("bypass freq");
  chk_normal_cmd:
    assert property ($past(aresetn) && !vf_force && !$past(vf_force)
      |-> cmd_freq == $past(regulator_freq)) else $error("normal freq");
  chk_sleep_run:
    assert property (asleep |-> !drive_run) else $error("run in sleep");
  chk_one_step:
    assert property (n_on <= $past(n_on) + 3'h1) else $error("two relays");
  chk_stage_gap:
    assert property (n_on > $past(n_on) |=> $stable(staged_motor_outputs))
      else $error("no blank cycle");
  chk_ramp_up:
    assert property (n_on > $past(n_on) |-> ramp_up) else $error("ramp up");
  chk_ramp_down:
    assert property (drive_run && $stable(interlock_inputs) &&
      n_on == $past(n_on) - 3'h1 |-> !ramp_up) else $error("ramp down");
  chk_pulse_once:
    assert property (bypass_restart |=> !bypass_restart) else $error("pulse");
endmodule
bind mms_top mms_top_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .aclk, .aresetn, .feedback, .regulator_freq, .staged_motor_outputs,
  .drive_run, .cmd_freq, .ramp_up, .bypass_restart, .pid_enable, .vf_force,
  .asleep, .interlock_inputs);

/* File: tb/tb_mms_top.sv */
// self-checking bench of the relay stager
`timescale 1ns/10ps
module tb_mms_top;
  localparam int TK = 20;
  localparam logic [33:0] ALL = '1;
  logic aclk = '0, aresetn = '0, rl_on = 1'h1;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic [3:0] s_axi_wstrb = 4'hf, fault = '0, rl_last = '0, nxt;
  logic [15:0] out_freq = '0, reference = '0, feedback = '0;
  logic [15:0] regulator_freq = '0, cmd_freq, ramp_time;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, drive_run, ramp_up, bypass_restart, pid_enable;
  logic vf_force, asleep;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [3:0] interlock_inputs, staged_motor_outputs, rl_exp[$];
  logic [33:0] rd_exp[$], rd_msk[$], rd_seen, rd_want;
  int failures = 0, n_tests = 0;
  integer seed = 85;
  mms_top #(.TICK_CYCLES(TK)) u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .out_freq, .reference, .feedback, .regulator_freq, .interlock_inputs,
    .staged_motor_outputs, .drive_run, .cmd_freq, .ramp_time, .ramp_up,
    .bypass_restart, .pid_enable, .vf_force, .asleep);
  mms_relay_model u_relays (.aclk, .fault, .interlock_inputs);
  //////////////////////////////////////////////////////////////////////////
  // clock and random regulator output
  always #20 aclk = ~aclk;
  always @(posedge aclk) regulator_freq <= 16'($random(seed));
  // relay changes against the oldest expected pattern
  always @(negedge aclk) begin
    if (aresetn && rl_on && staged_motor_outputs !== rl_last) begin
      nxt = rl_exp.size() > 0 ? rl_exp.pop_front() : 4'hx;
      check("relays", staged_motor_outputs, nxt);
    end
    rl_last = staged_motor_outputs;
  end
  // read data against the oldest expected word
  always @(negedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      rd_seen = {s_axi_rresp, s_axi_rdata} & rd_msk.pop_front();
      rd_want = rd_exp.pop_front();
      check("read", rd_seen, rd_want);
    end
  end
  task automatic check(input string nm, input logic [33:0] seen,
                       input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic tmo(input logic bad);
    if (bad) begin
      failures++;
      $display("[ERR] wait exp done seen timeout");
      stop_test();
    end
  endtask
  task automatic do_reset();
    aresetn <= 1'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    logic ta, tw, tb;
    n = 0;
    tb = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!tb && n < 200) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge aclk);
      n++;
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tb) s_axi_bready <= 1'h0;
    end
    if (tb) check("bresp", s_axi_bresp, {a >= 32'h50, 1'b0});
    tmo(!tb);
  endtask
  task automatic rd(input logic [31:0] a, input logic [33:0] e,
                    input logic [33:0] m);
    int n;
    logic ta, tr;
    n = 0;
    tr = 1'h0;
    rd_exp.push_back(e);
    rd_msk.push_back(m);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!tr && n < 200) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      @(posedge aclk);
      n++;
      if (ta) s_axi_arvalid <= 1'h0;
      if (tr) s_axi_rready <= 1'h0;
    end
    tmo(!tr);
  endtask
  task automatic wait_rl(input logic [3:0] v);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (staged_motor_outputs !== v && n < 20000);
    tmo(staged_motor_outputs !== v);
    @(posedge aclk);
  endtask
  task automatic wait_bit(ref logic s, input logic v);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (s !== v && n < 20000);
    tmo(s !== v);
    @(posedge aclk);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    do_reset();
    rd(32'h04, 34'h14, ALL);
    rd(32'h08, 34'h1387, ALL);
    wr(32'h54, 32'hff);
    rd(32'h54, 34'h0, ALL);
    rd(32'h58, 34'h200000000, 34'h300000000);
    // mode 0 from motor three, on and then off in reverse
    wr(32'h04, 32'h34);
    wr(32'h28, 32'h2);
    wr(32'h2c, 32'h2);
    wr(32'h30, 32'h00070005);
    reference <= 16'h64;
    feedback <= 16'ha;
    out_freq <= 16'h1388;
    rl_exp = '{4'h4, 4'hc, 4'hd, 4'hf};
    wr(32'h00, 32'h1);
    wait_rl(4'hf);
    check("ramp", {ramp_up, ramp_time}, {1'h1, 16'h5});
    rl_exp = '{4'hd, 4'hc, 4'h4, 4'h0};
    out_freq <= 16'h3e8;
    feedback <= 16'h64;
    wait_rl(4'h0);
    check("ramp", {ramp_up, ramp_time}, {1'h0, 16'h7});
    wr(32'h3c, 32'h7d0);
    wr(32'h40, 32'h32);
    repeat (10 * TK) @(posedge aclk);
    check("asleep", asleep, 1'h0);
    wr(32'h38, 32'h3);
    wait_bit(asleep, 1'h1);
    check("run", drive_run, 1'h0);
    feedback <= 16'ha;
    wait_bit(asleep, 1'h0);
    check("run", drive_run, 1'h1);
    // interlock loss mid-run restages without the failed motor
    do_reset();
    out_freq <= 16'h1388;
    rl_exp = '{4'h1, 4'h3, 4'h7, 4'hf};
    wr(32'h28, 32'h2);
    wr(32'h00, 32'h5);
    wait_rl(4'hf);
    rl_exp = '{4'h0, 4'h1, 4'h3, 4'hb};
    fault <= 4'h4;
    wait_rl(4'hb);
    check("left", rl_exp.size(), 34'h0);
    // bypass from an analogue source, not from the keypad
    do_reset();
    rl_on = 1'h0;
    wr(32'h00, 32'h103);
    repeat (3) @(posedge aclk);
    check("bypass", {pid_enable, vf_force, cmd_freq}, 18'h1000a);
    wr(32'h00, 32'h3);
    repeat (3) @(posedge aclk);
    check("keypad", {pid_enable, vf_force}, 2'h2);
    wr(32'h00, 32'h103);
    out_freq <= 16'h1770;
    wait_bit(bypass_restart, 1'h1);
    // mode 1 rotation after a minute of auxiliary run time
    do_reset();
    rl_on = 1'h1;
    out_freq <= 16'h1388;
    rl_exp = '{4'h1};
    wr(32'h28, 32'h2);
    wr(32'h2c, 32'h2);
    wr(32'h44, 32'h1);
    wr(32'h48, 32'h32);
    wr(32'h00, 32'h11);
    wait_rl(4'h1);
    out_freq <= 16'hfa0;
    repeat (605 * TK) @(posedge aclk);
    rd(32'h54, 34'h1, 34'h30000ff3f);
    reference <= 16'ha;
    out_freq <= 16'h3e8;
    rl_exp = '{4'h0};
    wait_rl(4'h0);
    repeat (4 * TK) @(posedge aclk);
    rd(32'h50, 34'h40, 34'h3000000c0);
    rd(32'h54, 34'h0, 34'h30000ff3f);
    reference <= 16'h64;
    out_freq <= 16'h1388;
    rl_exp = '{4'h2};
    wait_rl(4'h2);
    stop_test();
  end
endmodule
